//--- rtl/array_clock_enable.v
// array clock enable generator: one-cycle tick at the selected counting rate
// assumes ext_clk_pin is asynchronous and toggles slower than ref_clk / 2
`timescale 1ns/1ps
`default_nettype none
`include "cnt_wdt_defs.vh"

module array_clock_enable
(
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // source selection
  input wire [2:0] clock_source_select,
  input wire ext_clk_pin,
  // counting enable
  output reg tick
);

  reg ext_s1_r;
  reg ext_s2_r;
  reg ext_prev_r;
  reg [3:0] div_r;
  reg [3:0] div_last;

  // ----------------------------------------------------------------
  // synchroniser and edge memory for the external source
  // ----------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end
    else
    begin
      ext_s1_r <= ext_clk_pin;
      ext_s2_r <= ext_s1_r;
      ext_prev_r <= ext_s2_r;
    end
  end

  // divider end count for the selected prescale
  always @*
  begin
    div_last = (clock_source_select == `CPS_DIV4) ? `DIV4_LAST : `DIV12_LAST;
  end

  // ----------------------------------------------------------------
  // divider and tick selection
  // ----------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      div_r <= 4'h0;
      tick <= 1'b0;
    end
    else
    begin
      if (div_r >= div_last)
        div_r <= 4'h0;
      else
        div_r <= div_r + 4'h1;
      case (clock_source_select)
        `CPS_DIV12: tick <= (div_r >= div_last);
        `CPS_DIV4: tick <= (div_r >= div_last);
        `CPS_EXT: tick <= ext_s2_r & ~ext_prev_r;
        default: tick <= 1'b1;
      endcase
    end
  end

endmodule // array_clock_enable
`default_nettype wire

//--- rtl/cnt_wdt_defs.vh
// constants for the counter array with frequency output and watchdog
// assumes byte addresses on a 32-bit register bus, 8-bit registers in the low bits
`ifndef CNT_WDT_DEFS_VH
`define CNT_WDT_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_MODE 8'h04
`define OFS_CNT_LO 8'h08
`define OFS_CNT_HI 8'h0c
`define OFS_MOD_MODE 8'h10
`define OFS_MOD_LO 8'h20
`define OFS_MOD_HI 8'h30
`define OFS_IRQ_STAT 8'h40
`define OFS_IRQ_CLR 8'h44
`define OFS_IRQ_EN 8'h48

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_OVF 7
`define CTRL_RUN 6
`define CTRL_WDT_MATCH 2
`define MODE_IDLE_FRZ 7
`define MODE_WDT_EN 6
`define MODE_CPS_HI 3
`define MODE_CPS_LO 1
`define MM_CMP_EN 6
`define MM_TOG_EN 1
`define MM_PWM_EN 0

// ----------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------
`define MODE_RST 8'h00
`define NUM_MODS 3
`define WDT_MOD 2
`define NUM_EVENTS 4

// ----------------------------------------------------------------
// clock source codes and divider counts
// ----------------------------------------------------------------
`define CPS_DIV12 3'h0
`define CPS_DIV4 3'h1
`define CPS_EXT 3'h2
`define DIV12_LAST 4'hb
`define DIV4_LAST 4'h3

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- rtl/cnt_wdt_top.v
// counter array with frequency output modules and watchdog, AXI4-Lite slave
// assumes one write and one read outstanding; aw and w offered together
`timescale 1ns/1ps
`default_nettype none
`include "cnt_wdt_defs.vh"

module cnt_wdt_top
(
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // axi4-lite write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // clock source pin and idle state
  input wire ext_clk_pin,
  input wire cpu_idle,
  // outputs
  output reg [`NUM_MODS-1:0] module_output_pin,
  output reg watchdog_reset,
  output reg irq
);

  // ----------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------
  function is_mod_reg;
    input [7:0] a;
    input [7:0] base;
    begin
      is_mod_reg = (a[7:4] == base[7:4]) && (a[3:2] < `NUM_MODS) && (a[1:0] == 2'h0);
    end
  endfunction

  function is_reg;
    input [7:0] a;
    input [7:0] ofs;
    begin
      is_reg = (a == ofs);
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg run_r;
  reg idle_frz_r;
  reg wdt_en_r;
  reg [2:0] cps_r;
  reg [7:0] cnt_lo_r;
  reg [7:0] cnt_hi_r;
  reg [`NUM_MODS-1:0] flag_r;
  reg ovf_r;
  reg [`NUM_EVENTS-1:0] stat_r;
  reg [`NUM_EVENTS-1:0] irq_en_r;
  reg [7:0] mod_mode_r [0:`NUM_MODS-1];
  reg [7:0] mod_lo_r [0:`NUM_MODS-1];
  reg [7:0] mod_hi_r [0:`NUM_MODS-1];

  wire tick;
  wire wr;
  wire [7:0] wd;
  wire [7:0] wa;
  wire cnt_run;
  wire lo_ovf;
  wire full_ovf;
  wire [`NUM_MODS-1:0] match;
  wire [`NUM_EVENTS-1:0] ev;
  wire wdt_hit;
  wire wdt_force;
  reg [7:0] rd_data;
  reg rd_ok;
  // mode register reset image, bits picked one by one
  localparam [7:0] MODE_RST_V = `MODE_RST;

  // ----------------------------------------------------------------
  // counting rate selection
  // ----------------------------------------------------------------
  array_clock_enable u_clk_en
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .clock_source_select(cps_r),
    .ext_clk_pin(ext_clk_pin),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // bus write decode; both channels taken in the same cycle
  // ----------------------------------------------------------------
  assign wr = s_axi_awready & s_axi_wstrb[0];
  assign wd = s_axi_wdata[7:0];
  assign wa = s_axi_awaddr;

  // ----------------------------------------------------------------
  // counter and events
  // ----------------------------------------------------------------
  // counter runs on the tick when started or forced by the watchdog, unless the idle bit freezes it during cpu_idle
  assign cnt_run = tick & (run_r | wdt_en_r) & ~(idle_frz_r & cpu_idle);
  assign lo_ovf = cnt_run & (cnt_lo_r == 8'hff);
  assign full_ovf = lo_ovf & (cnt_hi_r == 8'hff);
  // reset when low byte overflows and module 2 high equals counter high
  assign wdt_hit = wdt_en_r & lo_ovf & (mod_hi_r[`WDT_MOD] == cnt_hi_r);
  assign wdt_force = wdt_en_r & wr & is_reg(wa, `OFS_CTRL) & wd[`CTRL_WDT_MATCH];
  assign ev = {full_ovf, match};

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnt_lo_r <= 8'h00;
      cnt_hi_r <= 8'h00;
    end
    else if (wr && !wdt_en_r && is_reg(wa, `OFS_CNT_LO))
      cnt_lo_r <= wd;
    else if (wr && !wdt_en_r && is_reg(wa, `OFS_CNT_HI))
      cnt_hi_r <= wd;
    else if (cnt_run)
    begin
      cnt_lo_r <= cnt_lo_r + 8'h01;
      if (lo_ovf)
        cnt_hi_r <= cnt_hi_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // capture/compare modules
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_MODS; gi = gi + 1)
    begin : g_mod
      wire locked;
      wire freq;
      wire timer;
      // module 2 is held as software timer while the watchdog runs
      assign locked = (gi == `WDT_MOD) && wdt_en_r;
      assign freq = ~locked & mod_mode_r[gi][`MM_CMP_EN] & mod_mode_r[gi][`MM_TOG_EN]
        & mod_mode_r[gi][`MM_PWM_EN];
      assign timer = locked | (mod_mode_r[gi][`MM_CMP_EN] & ~mod_mode_r[gi][`MM_PWM_EN]);
      assign match[gi] = cnt_run & (freq ? (mod_lo_r[gi] == cnt_lo_r)
        : (timer & ({mod_hi_r[gi], mod_lo_r[gi]} == {cnt_hi_r, cnt_lo_r})));

      // mode register, locked for module 2 under the watchdog
      always @(posedge ref_clk)
      begin
        if (rst)
          mod_mode_r[gi] <= 8'h00;
        else if (wr && !locked && is_mod_reg(wa, `OFS_MOD_MODE) && (wa[3:2] == gi))
          mod_mode_r[gi] <= wd;
      end

      // low byte: written, or advanced by the interval on a frequency match
      always @(posedge ref_clk)
      begin
        if (rst)
          mod_lo_r[gi] <= 8'h00;
        else if (wr && is_mod_reg(wa, `OFS_MOD_LO) && (wa[3:2] == gi))
          mod_lo_r[gi] <= wd;
        else if (freq && match[gi])
          mod_lo_r[gi] <= mod_lo_r[gi] + mod_hi_r[gi];
      end

      // high byte: plain store, or watchdog refresh
      always @(posedge ref_clk)
      begin
        if (rst)
          mod_hi_r[gi] <= 8'h00;
        else if (wr && is_mod_reg(wa, `OFS_MOD_HI) && (wa[3:2] == gi))
        begin
          if (locked)
            mod_hi_r[gi] <= cnt_hi_r + mod_lo_r[gi];
          else
            mod_hi_r[gi] <= wd;
        end
      end

      // output pin toggles on each frequency match
      always @(posedge ref_clk)
      begin
        if (rst)
          module_output_pin[gi] <= 1'b0;
        else if (freq && match[gi])
          module_output_pin[gi] <= ~module_output_pin[gi];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // control and mode registers
  // ----------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      run_r <= 1'b0;
      flag_r <= {`NUM_MODS{1'b0}};
      ovf_r <= 1'b0;
    end
    else
    begin
      // flags: software value, events set over a clear
      if (wr && is_reg(wa, `OFS_CTRL))
      begin
        run_r <= wd[`CTRL_RUN];
        flag_r <= wd[`NUM_MODS-1:0] | match;
        ovf_r <= wd[`CTRL_OVF] | full_ovf;
      end
      else
      begin
        flag_r <= flag_r | match;
        ovf_r <= ovf_r | full_ovf;
      end
    end
  end

  // source select and idle bit frozen under the watchdog
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      idle_frz_r <= MODE_RST_V[`MODE_IDLE_FRZ];
      wdt_en_r <= MODE_RST_V[`MODE_WDT_EN];
      cps_r <= 3'h0;
    end
    else if (wr && is_reg(wa, `OFS_MODE))
    begin
      wdt_en_r <= wd[`MODE_WDT_EN];
      if (!wdt_en_r)
      begin
        idle_frz_r <= wd[`MODE_IDLE_FRZ];
        cps_r <= wd[`MODE_CPS_HI:`MODE_CPS_LO];
      end
    end
  end

  // ----------------------------------------------------------------
  // watchdog reset pulse and interrupt
  // ----------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (rst)
      watchdog_reset <= 1'b0;
    else
      watchdog_reset <= wdt_hit | wdt_force;
  end

  // sticky status, write-one clear, set wins
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      stat_r <= {`NUM_EVENTS{1'b0}};
      irq_en_r <= {`NUM_EVENTS{1'b0}};
      irq <= 1'b0;
    end
    else
    begin
      if (wr && is_reg(wa, `OFS_IRQ_CLR))
        stat_r <= (stat_r & ~wd[`NUM_EVENTS-1:0]) | ev;
      else
        stat_r <= stat_r | ev;
      if (wr && is_reg(wa, `OFS_IRQ_EN))
        irq_en_r <= wd[`NUM_EVENTS-1:0];
      irq <= |(stat_r & irq_en_r);
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always @*
  begin
    rd_data = 8'h00;
    rd_ok = 1'b1;
    if (is_reg(s_axi_araddr, `OFS_CTRL))
      rd_data = {ovf_r, run_r, 3'h0, flag_r};
    else if (is_reg(s_axi_araddr, `OFS_MODE))
      rd_data = {idle_frz_r, wdt_en_r, 2'h0, cps_r, 1'b0};
    else if (is_reg(s_axi_araddr, `OFS_CNT_LO))
      rd_data = cnt_lo_r;
    else if (is_reg(s_axi_araddr, `OFS_CNT_HI))
      rd_data = cnt_hi_r;
    else if (is_mod_reg(s_axi_araddr, `OFS_MOD_MODE))
      rd_data = mod_mode_r[s_axi_araddr[3:2]];
    else if (is_mod_reg(s_axi_araddr, `OFS_MOD_LO))
      rd_data = mod_lo_r[s_axi_araddr[3:2]];
    else if (is_mod_reg(s_axi_araddr, `OFS_MOD_HI))
      rd_data = mod_hi_r[s_axi_araddr[3:2]];
    else if (is_reg(s_axi_araddr, `OFS_IRQ_STAT))
      rd_data = {4'h0, stat_r};
    else if (is_reg(s_axi_araddr, `OFS_IRQ_CLR))
      rd_data = 8'h00;
    else if (is_reg(s_axi_araddr, `OFS_IRQ_EN))
      rd_data = {4'h0, irq_en_r};
    else
      rd_ok = 1'b0;
  end

  // ----------------------------------------------------------------
  // axi4-lite handshakes
  // ----------------------------------------------------------------
  // write: take aw and w together, answer the next cycle
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      if (s_axi_awready)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (is_reg(wa, `OFS_CTRL) || is_reg(wa, `OFS_MODE)
          || is_reg(wa, `OFS_CNT_LO) || is_reg(wa, `OFS_CNT_HI)
          || is_mod_reg(wa, `OFS_MOD_MODE) || is_mod_reg(wa, `OFS_MOD_LO)
          || is_mod_reg(wa, `OFS_MOD_HI) || is_reg(wa, `OFS_IRQ_STAT)
          || is_reg(wa, `OFS_IRQ_CLR) || is_reg(wa, `OFS_IRQ_EN))
          ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read: take ar, return data the next cycle
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_data};
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // cnt_wdt_top
`default_nettype wire

//--- sim/cnt_wdt_monitor.sv
// checker for the counter array block: bus handshakes and watchdog outputs
// assumes it is bound onto cnt_wdt_top and sees one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "cnt_wdt_defs.vh"

module cnt_wdt_monitor
(
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // register bus
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // outputs
  input wire watchdog_reset,
  input wire irq
);
  reg wdt_on_r;
  reg fired_r;
  reg [3:0] irq_en_r;
  wire wr_hit;

  // a word is written at this edge
  assign wr_hit = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready & s_axi_wstrb[0];

  // shadows of watchdog state and interrupt enable
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      wdt_on_r <= 1'b0;
      fired_r <= 1'b0;
      irq_en_r <= 4'h0;
    end
    else
    begin
      if (wr_hit && s_axi_awaddr == `OFS_MODE)
        wdt_on_r <= s_axi_wdata[`MODE_WDT_EN];
      if (wr_hit && s_axi_awaddr == `OFS_IRQ_EN)
        irq_en_r <= s_axi_wdata[3:0];
      if (watchdog_reset)
        fired_r <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence force_wr;
    wr_take ##0 (s_axi_awaddr == `OFS_CTRL && s_axi_wstrb[0]
      && s_axi_wdata[`CTRL_WDT_MATCH] && wdt_on_r);
  endsequence

  aw_w_pair_a: assert property (s_axi_awready == s_axi_wready)
    else $error("awready and wready differ");
  write_answer_a: assert property (wr_take |=> s_axi_bvalid)
    else $error("no write response after handshake");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && s_axi_rdata[31:8] == 24'h000000)
    else $error("read answer late or upper bits set");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  wdt_pulse_a: assert property ($rose(watchdog_reset) |=> !watchdog_reset)
    else $error("watchdog reset longer than one cycle");
  force_reset_a: assert property (force_wr |-> ##[1:2] watchdog_reset)
    else $error("forced watchdog reset missing");
  wdt_quiet_a: assert property (!wdt_on_r && !$past(wdt_on_r) && !fired_r |-> !watchdog_reset)
    else $error("watchdog reset while disabled");
  irq_masked_a: assert property (irq_en_r == 4'h0 && $past(irq_en_r) == 4'h0 |-> !irq)
    else $error("interrupt while all enables clear");
endmodule // cnt_wdt_monitor

bind cnt_wdt_top cnt_wdt_monitor u_cnt_wdt_monitor (.ref_clk(ref_clk), .rst(rst),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .watchdog_reset(watchdog_reset), .irq(irq));

`default_nettype wire

//--- sim/far_side_model.sv
// far side model: square wave pins and the system reset input
// assumes pins and the reset pulse are sampled on ref_clk
`timescale 1ns/1ps
`default_nettype none

module far_side_model
(
  // clock
  input wire logic ref_clk,
  // observed lines
  input wire logic [2:0] pin,
  input wire logic wdt_reset,
  // measurements
  output int gap0,
  output int toggles1,
  output int resets,
  output int rst_cyc,
  output int cyc
);
  int last0;
  logic [2:0] pin_q;

  // start with nothing seen
  initial
  begin
    {gap0, toggles1, resets, rst_cyc, cyc, last0} = '0;
    pin_q = 3'h0;
  end

  // time stamps of pin 0 edges and reset pulses, count of pin 1 toggles
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    pin_q <= pin;
    if (pin[0] !== pin_q[0])
    begin
      gap0 <= cyc - last0;
      last0 <= cyc;
    end
    if (pin[1] !== pin_q[1])
      toggles1 <= toggles1 + 1;
    if (wdt_reset === 1'b1)
    begin
      resets <= resets + 1;
      rst_cyc <= cyc;
    end
  end
endmodule // far_side_model

`default_nettype wire

//--- sim/tb_top.sv
// bench for the counter array block: bus tasks and one task per scenario
// assumes the design header on the include path
`timescale 1ns/1ps
`default_nettype none
`include "cnt_wdt_defs.vh"

module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] aw = 8'h00;
  logic [7:0] ar = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0] ws = 4'hf;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, ext = 1'b0, idle = 1'b0;
  logic awr, wr, bv, arr, rv, wdr, irq;
  logic [1:0] bresp, rresp, b_last, r_last;
  logic [31:0] rd;
  logic [2:0] pin;
  int gap0, toggles1, resets, rst_cyc, cyc;
  int mismatches = 0;
  int n_tests = 0;

  always #10 ref_clk = ~ref_clk;

  cnt_wdt_top u_cnt_wdt_top (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ar),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .ext_clk_pin(ext), .cpu_idle(idle),
    .module_output_pin(pin), .watchdog_reset(wdr), .irq(irq));
  far_side_model u_far_side_model (.ref_clk(ref_clk), .pin(pin), .wdt_reset(wdr), .gap0(gap0),
    .toggles1(toggles1), .resets(resets), .rst_cyc(rst_cyc), .cyc(cyc));

  // ----
  // report, compare and bus tasks
  // ----
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic tmo;
    mismatches++;
    test_done;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_in(input logic [31:0] got, input int lo, input int hi);
    n_tests++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    aw <= a;
    wd <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (awr)
        awv <= 1'b0;
      if (wr)
        wv <= 1'b0;
    end
    while (bv !== 1'b1 && n < 20);
    if (n >= 20)
      tmo;
    b_last = bresp;
    br <= 1'b0;
  endtask
  task automatic rd8(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge ref_clk);
    ar <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (arr)
        arv <= 1'b0;
    end
    while (rv !== 1'b1 && n < 20);
    if (n >= 20)
      tmo;
    d = rd;
    r_last = rresp;
    rr <= 1'b0;
  endtask
  task automatic wait_tog;
    int n;
    logic p;
    n = 0;
    p = pin[0];
    while (pin[0] === p && n < 300)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 300)
      tmo;
    repeat (3) @(posedge ref_clk);
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_reset_map;
    logic [31:0] v;
    rd8(`OFS_MODE, v);
    chk(v, 32'h0);
    rd8(8'h7c, v);
    chk(r_last, `RESP_SLVERR);
    wr8(8'h7c, 8'h55);
    chk(b_last, `RESP_SLVERR);
  endtask
  task automatic t_clk_src;
    logic [31:0] v;
    int e [4] = '{8, 24, 12, 96};
    for (int c = 0; c < 4; c++)
    begin
      wr8(`OFS_CNT_LO, 8'h00);
      wr8(`OFS_MODE, 8'(c * 2));
      wr8(`OFS_CTRL, 8'h40);
      repeat (24)
      begin
        repeat (4) @(posedge ref_clk);
        ext <= ~ext;
      end
      wr8(`OFS_CTRL, 8'h00);
      rd8(`OFS_CNT_LO, v);
      chk_in(v, e[c] - 1, e[c] + e[c] / 16 + 2);
    end
  endtask
  task automatic t_freq;
    wr8(`OFS_MODE, 8'h06);
    wr8(`OFS_CNT_LO, 8'h00);
    wr8(`OFS_MOD_LO, 8'h10);
    wr8(`OFS_MOD_HI, 8'h04);
    wr8(`OFS_MOD_MODE, 8'h43);
    wr8(8'h24, 8'h10);
    wr8(8'h34, 8'h04);
    wr8(8'h14, 8'h03);
    wr8(`OFS_CTRL, 8'h40);
    repeat (40) @(posedge ref_clk);
    chk_in(gap0, 4, 4);
    chk_in(toggles1, 0, 0);
    wr8(`OFS_MOD_HI, 8'h00);
    repeat (600) @(posedge ref_clk);
    chk_in(gap0, 256, 256);
  endtask
  task automatic t_irq;
    logic [31:0] v;
    wr8(`OFS_IRQ_EN, 8'h01);
    wait_tog;
    chk(irq, 1'b1);
    wr8(`OFS_IRQ_CLR, 8'h01);
    rd8(`OFS_IRQ_STAT, v);
    chk(v[0], 1'b0);
    chk(irq, 1'b0);
    wr8(`OFS_IRQ_EN, 8'h00);
    wait_tog;
    rd8(`OFS_IRQ_STAT, v);
    chk(v[0], 1'b1);
    chk(irq, 1'b0);
  endtask
  task automatic t_wdt;
    logic [31:0] u, v;
    int t0, n;
    wr8(`OFS_CTRL, 8'h00);
    wr8(`OFS_CNT_LO, 8'h00);
    wr8(`OFS_CNT_HI, 8'h00);
    wr8(8'h28, 8'h02);
    wr8(`OFS_MODE, 8'h46);
    wr8(8'h38, 8'h00);
    rd8(`OFS_CTRL, v);
    chk(v[6], 1'b0);
    wr8(`OFS_CNT_HI, 8'h80);
    rd8(`OFS_CNT_HI, v);
    chk(v, 32'h0);
    wr8(`OFS_MODE, 8'hc0);
    rd8(`OFS_MODE, v);
    chk(v, 32'h46);
    rd8(8'h18, u);
    wr8(8'h18, 8'h00);
    rd8(8'h18, v);
    chk(v, u);
    chk(pin[2], 1'b0);
    wr8(`OFS_CTRL, 8'h00);
    rd8(`OFS_CNT_LO, u);
    rd8(`OFS_CNT_LO, v);
    chk_in(v[7:0] - u[7:0], 1, 8);
    wr8(8'h38, 8'h00);
    t0 = cyc;
    rd8(`OFS_CNT_LO, v);
    chk_in(resets, 0, 0);
    n = 0;
    while (resets == 0 && n < 1000)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 1000)
      tmo;
    chk_in(rst_cyc - t0, 760 - v[7:0], 780 - v[7:0]);
  endtask
  task automatic t_force;
    wr8(`OFS_CTRL, 8'h04);
    repeat (3) @(posedge ref_clk);
    chk_in(resets, 2, 2);
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset_map;
    t_clk_src;
    t_freq;
    t_irq;
    t_wdt;
    t_force;
    test_done;
  end
endmodule // tb_top

`default_nettype wire
